// ==== mhe_defs.svh ====
// address map, field positions and fixed constants of the digest engine
`ifndef MHE_DEFS_SVH
`define MHE_DEFS_SVH

// byte-wide address map
`define MHE_IN_LO      16'h7A00
`define MHE_IN_HI      16'h7A3F
`define MHE_CTX_IN     16'h7A40
`define MHE_RES        16'h7A70
`define MHE_CTRL       16'h7AA0
`define MHE_STAT       16'h7AA1
`define MHE_CTX_BYTES  16'h001C

// status fields, write one to clear the done bit
`define MHE_ST_DONE    0
`define MHE_ST_BUSY    1

// block geometry
`define MHE_BLK_BYTES  64
`define MHE_PTR_LAST   7'h3F
`define MHE_PAD_MAX    7'h37
`define MHE_PAD_BYTE   8'h80
`define MHE_LEN_HI     4'hE
`define MHE_LEN_LO     4'hF
`define MHE_MD5_BYTES  5'h10
`define MHE_DIG_BYTES  5'h14
`define MHE_CTX_LAST   5'h1B
`define MHE_CTX_STATE  20

// last compression cycle, four steps per cycle
`define MHE_MD5_LAST   5'h0F
`define MHE_SHA_LAST   5'h13

// sha-1 round group bounds and constants
`define MHE_SHA_T1     7'h14
`define MHE_SHA_T2     7'h28
`define MHE_SHA_T3     7'h3C
`define MHE_SHA_K0     32'h5A827999
`define MHE_SHA_K1     32'h6ED9EBA1
`define MHE_SHA_K2     32'h8F1BBCDC
`define MHE_SHA_K3     32'hCA62C1D6

// initial chaining values
`define MHE_IV0        32'h67452301
`define MHE_IV1        32'hEFCDAB89
`define MHE_IV2        32'h98BADCFE
`define MHE_IV3        32'h10325476
`define MHE_IV4        32'hC3D2E1F0

// md5 block turnaround budget in ns and its cycle count (rounded down)
`define MHE_CLK_NS       25
`define MHE_MD5_DONE_NS  500
`define MHE_MD5_DONE_CYC ((`MHE_MD5_DONE_NS) / (`MHE_CLK_NS))

`endif

// ==== mhe_pkg.sv ====
// types shared by the digest engine modules
`default_nettype none
package mhe_pkg;

  typedef logic [31:0] mhe_word_t;

  // one bus request, byte wide
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } mhe_bus_req_s;

  // control register layout, bit 0 is algo
  typedef struct packed {
    logic last_block_flag;
    logic hash_engine_enable;
    logic resume_context_select;
    logic hash_algo_select;
  } mhe_ctrl_s;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_LOAD = 4'b0010,
    S_RUN  = 4'b0100,
    S_ADD  = 4'b1000
  } mhe_state_e;

endpackage
`default_nettype wire

// ==== mhe_md5_step.sv ====
// one md5 step: round function, table constant and rotate
`include "mhe_defs.svh"
`default_nettype none
module mhe_md5_step
(
  input  wire mhe_pkg::mhe_word_t a,
  input  wire mhe_pkg::mhe_word_t b,
  input  wire mhe_pkg::mhe_word_t c,
  input  wire mhe_pkg::mhe_word_t d,
  input  wire mhe_pkg::mhe_word_t m,
  input  wire logic [5:0]         idx,
  output var  mhe_pkg::mhe_word_t na,
  output var  mhe_pkg::mhe_word_t nb,
  output var  mhe_pkg::mhe_word_t nc,
  output var  mhe_pkg::mhe_word_t nd
);
  import mhe_pkg::*;

  // sine-derived additive constants
  localparam mhe_word_t MD5_K [0:63] = '{
    32'hD76AA478, 32'hE8C7B756, 32'h242070DB, 32'hC1BDCEEE,
    32'hF57C0FAF, 32'h4787C62A, 32'hA8304613, 32'hFD469501,
    32'h698098D8, 32'h8B44F7AF, 32'hFFFF5BB1, 32'h895CD7BE,
    32'h6B901122, 32'hFD987193, 32'hA679438E, 32'h49B40821,
    32'hF61E2562, 32'hC040B340, 32'h265E5A51, 32'hE9B6C7AA,
    32'hD62F105D, 32'h02441453, 32'hD8A1E681, 32'hE7D3FBC8,
    32'h21E1CDE6, 32'hC33707D6, 32'hF4D50D87, 32'h455A14ED,
    32'hA9E3E905, 32'hFCEFA3F8, 32'h676F02D9, 32'h8D2A4C8A,
    32'hFFFA3942, 32'h8771F681, 32'h6D9D6122, 32'hFDE5380C,
    32'hA4BEEA44, 32'h4BDECFA9, 32'hF6BB4B60, 32'hBEBFBC70,
    32'h289B7EC6, 32'hEAA127FA, 32'hD4EF3085, 32'h04881D05,
    32'hD9D4D039, 32'hE6DB99E5, 32'h1FA27CF8, 32'hC4AC5665,
    32'hF4292244, 32'h432AFF97, 32'hAB9423A7, 32'hFC93A039,
    32'h655B59C3, 32'h8F0CCC92, 32'hFFEFF47D, 32'h85845DD1,
    32'h6FA87E4F, 32'hFE2CE6E0, 32'hA3014314, 32'h4E0811A1,
    32'hF7537E82, 32'hBD3AF235, 32'h2AD7D2BB, 32'hEB86D391};

  // rotate amounts, by round and step within a group of four
  localparam logic [4:0] MD5_S [0:15] = '{
    5'h07, 5'h0C, 5'h11, 5'h16, 5'h05, 5'h09, 5'h0E, 5'h14,
    5'h04, 5'h0B, 5'h10, 5'h17, 5'h06, 5'h0A, 5'h0F, 5'h15};

  mhe_word_t  f;
  mhe_word_t  sum;
  logic [4:0] s;

  // round function by quarter
  always_comb
  begin
    unique case (idx[5:4])
      2'h0: f = (b & c) | (~b & d);
      2'h1: f = (d & b) | (~d & c);
      2'h2: f = b ^ c ^ d;
      2'h3: f = c ^ (b | ~d);
    endcase
  end

  // rotate never sees zero, so the right shift stays below 32
  assign s   = MD5_S[{idx[5:4], idx[1:0]}];
  assign sum = a + f + MD5_K[idx] + m;
  assign na  = d;
  assign nb  = b + ((sum << s) | (sum >> (6'h20 - {1'b0, s})));
  assign nc  = b;
  assign nd  = c;

endmodule
`default_nettype wire

// ==== mhe_sha1_step.sv ====
// one sha-1 step: mixing function, round constant and rotates
`include "mhe_defs.svh"
`default_nettype none
module mhe_sha1_step
(
  input  wire mhe_pkg::mhe_word_t a,
  input  wire mhe_pkg::mhe_word_t b,
  input  wire mhe_pkg::mhe_word_t c,
  input  wire mhe_pkg::mhe_word_t d,
  input  wire mhe_pkg::mhe_word_t e,
  input  wire mhe_pkg::mhe_word_t w,
  input  wire logic [6:0]         t,
  output var  mhe_pkg::mhe_word_t na,
  output var  mhe_pkg::mhe_word_t nb,
  output var  mhe_pkg::mhe_word_t nc,
  output var  mhe_pkg::mhe_word_t nd,
  output var  mhe_pkg::mhe_word_t ne
);
  import mhe_pkg::*;

  mhe_word_t f;
  mhe_word_t k;

  // round group picks function and constant
  always_comb
  begin
    if (t < `MHE_SHA_T1)
    begin
      f = (b & c) | (~b & d);
      k = `MHE_SHA_K0;
    end
    else if (t < `MHE_SHA_T2)
    begin
      f = b ^ c ^ d;
      k = `MHE_SHA_K1;
    end
    else if (t < `MHE_SHA_T3)
    begin
      f = (b & c) | (b & d) | (c & d);
      k = `MHE_SHA_K2;
    end
    else
    begin
      f = b ^ c ^ d;
      k = `MHE_SHA_K3;
    end
  end

  assign na = {a[26:0], a[31:27]} + f + e + k + w;
  assign nb = a;
  assign nc = {b[1:0], b[31:2]};
  assign nd = c;
  assign ne = d;

endmodule
`default_nettype wire

// ==== mhe_engine.sv ====
// md5 / sha-1 digest engine with input window, padding, context and result area
//
// The register offsets and the plain strobed port were left to the implementer.
`include "mhe_defs.svh"
`default_nettype none
// Functional notes
// - digest is 128 bits for MD5, 160 bits for SHA-1, any length.
// - one shared datapath; algo bit set selects SHA-1, clear selects MD5.
// - at enable, load standard start values or the saved context.
// - while enabled and idle, every byte written to the window joins the hash until the final digest seals it.
// - after 64 bytes, process the block and then raise block done; while last_block_flag is set, only the final digest raises it.
// - final transfer gets padded, digest placed at result area, done raised.
// - any address 7A00h..7A3Fh appends to the block; window is unreadable.
// - the final transfer may be of any byte length.
// - MD5 result is 16 bytes, left-justified, little-endian byte order within each word.
// - SHA-1 result is 20 bytes from the result address, big-endian.
// - in MD5 mode block done follows the block within 500 ns; the code raises none for full blocks while last_block_flag is set.
// - 28-byte context readable at 7A70h, restorable at 7A40h.
module mhe_engine
(
  input  wire logic                  clk_sys,
  input  wire logic                  sys_rst,
  input  wire mhe_pkg::mhe_bus_req_s bus_req,
  input  wire logic                  dma_start_bit,
  output var  logic [7:0]            bus_rdata,
  output var  logic                  block_done_flag,
  output var  logic                  hash_busy
);
  import mhe_pkg::*;

  mhe_ctrl_s  ctrl;
  mhe_ctrl_s  next_ctrl;
  mhe_state_e st;
  logic       dma_q;
  logic       fin_pend;
  logic       fin_last;
  logic       two_blk;
  logic       sealed;
  logic [6:0] ptr;
  logic [4:0] cnt;
  logic [63:0] msg_len;
  logic [63:0] len_bits;
  logic [63:0] ctx_len;
  mhe_word_t  blk [0:15];
  mhe_word_t  ext [0:19];
  mhe_word_t  h [0:4];
  mhe_word_t  wa;
  mhe_word_t  wb;
  mhe_word_t  wc;
  mhe_word_t  wd;
  mhe_word_t  we;
  logic [7:0] ctx_in [0:27];
  logic [7:0] res_byte;
  logic [15:0] ctx_off;
  logic [15:0] res_off;
  logic [4:0] lk;
  logic       hit_in;
  logic       hit_ctx;
  logic       hit_res;
  logic       wr_ctrl;
  logic       wr_stat;
  logic       en_rise;
  logic       accept;
  logic       pad_go;
  logic       last_cyc;
  logic       set_done;

  // bit offset of a byte lane: sha packs big-endian, md5 little-endian
  function automatic logic [4:0] lane_sh(input logic sha, input logic [1:0] k);
    return sha ? {~k, 3'b000} : {k, 3'b000};
  endfunction

  // length word placement at the block tail differs per algorithm
  function automatic mhe_word_t len_word(input logic sha, input logic w14,
                                         input logic [63:0] bits);
    return (sha == w14) ? bits[63:32] : bits[31:0];
  endfunction

  // md5 message word index per step
  function automatic logic [3:0] md5_g(input logic [5:0] i);
    logic [3:0] g;
    unique case (i[5:4])
      2'h0: g = i[3:0];
      2'h1: g = i[3:0] * 4'h5 + 4'h1;
      2'h2: g = i[3:0] * 4'h3 + 4'h5;
      2'h3: g = i[3:0] * 4'h7;
    endcase
    return g;
  endfunction

  // address decode; below-base addresses wrap high and miss
  // whole window
  assign hit_in    = (bus_req.addr >= `MHE_IN_LO) && (bus_req.addr <= `MHE_IN_HI);
  assign ctx_off   = bus_req.addr - `MHE_CTX_IN;
  assign res_off   = bus_req.addr - `MHE_RES;
  assign hit_ctx   = ctx_off < `MHE_CTX_BYTES;
  assign hit_res   = res_off < `MHE_CTX_BYTES;
  assign wr_ctrl   = bus_req.wr && (bus_req.addr == `MHE_CTRL);
  assign wr_stat   = bus_req.wr && (bus_req.addr == `MHE_STAT);
  assign next_ctrl = wr_ctrl ? mhe_ctrl_s'(bus_req.wdata[3:0]) : ctrl;
  assign en_rise   = next_ctrl.hash_engine_enable && !ctrl.hash_engine_enable;
  assign len_bits  = {msg_len[60:0], 3'b000};
  assign ctx_len   = {ctx_in[20], ctx_in[21], ctx_in[22], ctx_in[23],
                      ctx_in[24], ctx_in[25], ctx_in[26], ctx_in[27]};

  assign accept = (st == S_IDLE) && ctrl.hash_engine_enable && !sealed
                  && bus_req.wr && hit_in;
  assign pad_go = (st == S_IDLE) && !accept && fin_pend && !sealed;
  assign last_cyc = cnt == (ctrl.hash_algo_select ? `MHE_SHA_LAST : `MHE_MD5_LAST);
  assign set_done = (st == S_ADD) && !two_blk
                    && (fin_last || !ctrl.last_block_flag);

  // control register
  // algo select
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      ctrl <= '0;
    else
      ctrl <= next_ctrl;
  end

  // end of the final copy is the falling edge of the dma busy level
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      dma_q <= 1'b0;
    else
      dma_q <= dma_start_bit;
  end

  // finish request; a new request beats its own consumption
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst || !ctrl.hash_engine_enable)
      fin_pend <= 1'b0;
    else if (dma_q && !dma_start_bit && ctrl.last_block_flag)
      fin_pend <= 1'b1;
    else if (pad_go)
      fin_pend <= 1'b0;
  end

  // sequencer; dropping enable abandons any partial block
  // discard partial
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst || !ctrl.hash_engine_enable)
    begin
      st        <= S_IDLE;
      ptr       <= '0;
      cnt       <= '0;
      fin_last  <= 1'b0;
      two_blk   <= 1'b0;
      sealed    <= 1'b0;
      hash_busy <= 1'b0;
    end
    else
    begin
      unique case (st)
        S_IDLE:
        begin
          if (accept)
          begin
            ptr <= ptr + 7'h01;
            if (ptr == `MHE_PTR_LAST)
            begin
              st        <= S_LOAD;
              hash_busy <= 1'b1;
            end
          end
          else if (pad_go)
          begin
            fin_last  <= ptr <= `MHE_PAD_MAX;
            two_blk   <= ptr > `MHE_PAD_MAX;
            ptr       <= '0;
            st        <= S_LOAD;
            hash_busy <= 1'b1;
          end
        end
        S_LOAD:
        begin
          cnt <= '0;
          st  <= S_RUN;
        end
        S_RUN:
        begin
          cnt <= cnt + 5'h01;
          if (last_cyc)
            st <= S_ADD;
        end
        S_ADD:
        begin
          if (two_blk)
          begin
            two_blk  <= 1'b0;
            fin_last <= 1'b1;
            st       <= S_LOAD;
          end
          else
          begin
            ptr       <= '0;
            st        <= S_IDLE;
            hash_busy <= 1'b0;
            if (fin_last)
            begin
              fin_last <= 1'b0;
              sealed   <= 1'b1;
            end
          end
        end
        default:
        begin
          st        <= S_IDLE;
          hash_busy <= 1'b0;
        end
      endcase
    end
  end

  // message block: byte intake, padding, sha schedule window
  always_ff @(posedge clk_sys)
  begin
    if (accept)
      blk[ptr[5:2]][lane_sh(ctrl.hash_algo_select, ptr[1:0]) +: 8] <= bus_req.wdata;
    else if (pad_go)
    begin
      for (int k = 0; k < `MHE_BLK_BYTES; k++)
      begin
        if (7'(k) == ptr)
          blk[4'(k >> 2)][lane_sh(ctrl.hash_algo_select, 2'(k)) +: 8] <= `MHE_PAD_BYTE;
        else if (7'(k) > ptr)
          blk[4'(k >> 2)][lane_sh(ctrl.hash_algo_select, 2'(k)) +: 8] <= 8'h00;
      end
      if (ptr <= `MHE_PAD_MAX)
      begin
        blk[`MHE_LEN_HI] <= len_word(ctrl.hash_algo_select, 1'b1, len_bits);
        blk[`MHE_LEN_LO] <= len_word(ctrl.hash_algo_select, 1'b0, len_bits);
      end
    end
    else if ((st == S_RUN) && ctrl.hash_algo_select)
    begin
      for (int i = 0; i < 16; i++)
        blk[i] <= ext[i + 4];
    end
    else if ((st == S_ADD) && two_blk)
    begin
      for (int i = 0; i < 14; i++)
        blk[i] <= '0;
      blk[`MHE_LEN_HI] <= len_word(ctrl.hash_algo_select, 1'b1, len_bits);
      blk[`MHE_LEN_LO] <= len_word(ctrl.hash_algo_select, 1'b0, len_bits);
    end
  end

  // sha schedule: four fresh words per cycle, chained in one cycle
  always_comb
  begin
    for (int i = 0; i < 16; i++)
      ext[i] = blk[i];
    for (int k = 0; k < 4; k++)
    begin
      ext[k + 16] = ext[k + 13] ^ ext[k + 8] ^ ext[k + 2] ^ ext[k];
      ext[k + 16] = {ext[k + 16][30:0], ext[k + 16][31]};
    end
  end

  // four steps per cycle keep md5 inside its turnaround budget
  // md5 latency
  mhe_word_t m_a [0:4];
  mhe_word_t m_b [0:4];
  mhe_word_t m_c [0:4];
  mhe_word_t m_d [0:4];
  mhe_word_t s_a [0:4];
  mhe_word_t s_b [0:4];
  mhe_word_t s_c [0:4];
  mhe_word_t s_d [0:4];
  mhe_word_t s_e [0:4];

  assign m_a[0] = wa;
  assign m_b[0] = wb;
  assign m_c[0] = wc;
  assign m_d[0] = wd;
  assign s_a[0] = wa;
  assign s_b[0] = wb;
  assign s_c[0] = wc;
  assign s_d[0] = wd;
  assign s_e[0] = we;

  for (genvar j = 0; j < 4; j++)
  begin : g_step
    mhe_md5_step u_md5 (
      .a   (m_a[j]),
      .b   (m_b[j]),
      .c   (m_c[j]),
      .d   (m_d[j]),
      .m   (blk[md5_g({cnt[3:0], 2'(j)})]),
      .idx ({cnt[3:0], 2'(j)}),
      .na  (m_a[j + 1]),
      .nb  (m_b[j + 1]),
      .nc  (m_c[j + 1]),
      .nd  (m_d[j + 1])
    );
    mhe_sha1_step u_sha (
      .a   (s_a[j]),
      .b   (s_b[j]),
      .c   (s_c[j]),
      .d   (s_d[j]),
      .e   (s_e[j]),
      .w   (blk[j]),
      .t   ({cnt, 2'(j)}),
      .na  (s_a[j + 1]),
      .nb  (s_b[j + 1]),
      .nc  (s_c[j + 1]),
      .nd  (s_d[j + 1]),
      .ne  (s_e[j + 1])
    );
  end

  // working variables
  always_ff @(posedge clk_sys)
  begin
    if (st == S_LOAD)
    begin
      wa <= h[0];
      wb <= h[1];
      wc <= h[2];
      wd <= h[3];
      we <= h[4];
    end
    else if (st == S_RUN)
    begin
      wa <= ctrl.hash_algo_select ? s_a[4] : m_a[4];
      wb <= ctrl.hash_algo_select ? s_b[4] : m_b[4];
      wc <= ctrl.hash_algo_select ? s_c[4] : m_c[4];
      wd <= ctrl.hash_algo_select ? s_d[4] : m_d[4];
      we <= s_e[4];
    end
  end

  // chaining state and message length
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      msg_len <= '0;
      for (int i = 0; i < 5; i++)
        h[i] <= '0;
    end
    else if (en_rise)
    begin
      if (next_ctrl.resume_context_select)
      begin
        for (int i = 0; i < `MHE_CTX_STATE; i++)
          h[i / 4][lane_sh(next_ctrl.hash_algo_select, 2'(i)) +: 8] <= ctx_in[i];
        msg_len <= {3'b000, ctx_len[63:3]};
      end
      else
      begin
        h[0]    <= `MHE_IV0;
        h[1]    <= `MHE_IV1;
        h[2]    <= `MHE_IV2;
        h[3]    <= `MHE_IV3;
        h[4]    <= next_ctrl.hash_algo_select ? `MHE_IV4 : 32'h0000_0000;
        msg_len <= '0;
      end
    end
    else
    begin
      if (accept)
        msg_len <= msg_len + 64'h1;
      if (st == S_ADD)
      begin
        h[0] <= h[0] + wa;
        h[1] <= h[1] + wb;
        h[2] <= h[2] + wc;
        h[3] <= h[3] + wd;
        if (ctrl.hash_algo_select)
          h[4] <= h[4] + we;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (bus_req.wr && hit_ctx)
      ctx_in[ctx_off[4:0]] <= bus_req.wdata;
  end

  // block done: hardware set beats a same-cycle software clear
  // write one clears
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      block_done_flag <= 1'b0;
    else if (set_done)
      block_done_flag <= 1'b1;
    else if (wr_stat && bus_req.wdata[`MHE_ST_DONE])
      block_done_flag <= 1'b0;
  end

  // result area byte: state then big-endian bit length
  // md5 left-justified
  assign lk = `MHE_CTX_LAST - res_off[4:0];
  always_comb
  begin
    res_byte = 8'h00;
    if (res_off[4:0] < `MHE_DIG_BYTES)
    begin
      if (ctrl.hash_algo_select || (res_off[4:0] < `MHE_MD5_BYTES))
        res_byte = h[res_off[4:2]][lane_sh(ctrl.hash_algo_select, res_off[1:0]) +: 8];
    end
    else
      res_byte = len_bits[{lk[2:0], 3'b000} +: 8];
  end

  // read port; the input window and unmapped space read as zero
  // window unreadable
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst || !bus_req.rd)
      bus_rdata <= 8'h00;
    else if (hit_ctx)
      bus_rdata <= ctx_in[ctx_off[4:0]];
    else if (hit_res)
      bus_rdata <= res_byte;
    else if (bus_req.addr == `MHE_CTRL)
      bus_rdata <= {4'h0, ctrl};
    else if (bus_req.addr == `MHE_STAT)
      bus_rdata <= {6'h00, hash_busy, block_done_flag};
    else
      bus_rdata <= 8'h00;
  end

endmodule
`default_nettype wire

// ==== mhe_checker.sv ====
// port-level assertions for the digest engine
`include "mhe_defs.svh"
`default_nettype none
module mhe_checker
(
  input wire logic                  clk_sys,
  input wire logic                  sys_rst,
  input wire mhe_pkg::mhe_bus_req_s bus_req,
  input wire logic                  dma_start_bit,
  input wire logic [7:0]            bus_rdata,
  input wire logic                  block_done_flag,
  input wire logic                  hash_busy
);
  import mhe_pkg::*;
  localparam int MD5_MAX = `MHE_MD5_DONE_CYC;
  logic [3:0] ctrl;
  logic [6:0] cnt;
  logic       win_wr;
  logic       take;
  logic       full;
  logic       w1c;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // bytes only count while enabled, idle and not in the final transfer
  assign win_wr = bus_req.wr && bus_req.addr >= `MHE_IN_LO && bus_req.addr <= `MHE_IN_HI;
  assign take   = win_wr && ctrl[2] && !ctrl[3] && !hash_busy;
  assign full   = take && cnt == 7'h3F;
  assign w1c    = bus_req.wr && bus_req.addr == `MHE_STAT && bus_req.wdata[0];
  // shadow of the control register
  always_ff @(posedge clk_sys)
    if (sys_rst)
      ctrl <= 4'h0;
    else if (bus_req.wr && bus_req.addr == `MHE_CTRL)
      ctrl <= bus_req.wdata[3:0];
  // block fill count, dropped with the enable
  always_ff @(posedge clk_sys)
    if (sys_rst || !ctrl[2] || full)
      cnt <= 7'h00;
    else if (take)
      cnt <= cnt + 7'h01;
  sequence s_md5_full;
    full && !ctrl[0];
  endsequence
  sequence s_md5_done;
    ##[1:MD5_MAX] block_done_flag;
  endsequence
  a_md5_done_bound: assert property (s_md5_full |-> s_md5_done)
    else $error("md5 block done late");
  a_busy_follows: assert property (full |-> ##[1:3] hash_busy)
    else $error("full block not taken up");
  a_done_from_busy: assert property ($rose(block_done_flag) |-> $past(hash_busy))
    else $error("done raised without processing");
  a_done_sticky: assert property (block_done_flag && !w1c |=> block_done_flag)
    else $error("done flag dropped by itself");
  a_done_clear: assert property (w1c && !hash_busy |=> !block_done_flag)
    else $error("done flag not cleared");
  a_window_unread: assert property (bus_req.rd && bus_req.addr[15:6] == 10'h1E8 |=>
    bus_rdata == 8'h00) else $error("window read not zero");
  a_ctrl_readback: assert property (bus_req.rd && bus_req.addr == `MHE_CTRL |=>
    bus_rdata == {4'h0, $past(ctrl)}) else $error("control readback wrong");
  a_idle_quiet: assert property (!ctrl[2] && !hash_busy |=> !hash_busy)
    else $error("disabled engine went busy");
  a_final_done: assert property ($fell(dma_start_bit) && ctrl[2] && ctrl[3] |->
    ##[1:60] block_done_flag) else $error("final digest late");
endmodule
bind mhe_engine mhe_checker u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus_req(bus_req),
  .dma_start_bit(dma_start_bit), .bus_rdata(bus_rdata),
  .block_done_flag(block_done_flag), .hash_busy(hash_busy));
`default_nettype wire

// ==== mhe_dma_model.sv ====
// dma model copying message bytes into the hash input window
`include "mhe_defs.svh"
`default_nettype none
module mhe_dma_model
(
  input  wire logic                  clk_sys,
  input  wire logic                  go,
  input  wire logic [511:0]          msg,
  input  wire logic [6:0]            len,
  input  wire logic [1:0]            gap,
  output var  mhe_pkg::mhe_bus_req_s dma_req,
  output var  logic                  dma_start_bit
);
  timeunit 1ns;
  timeprecision 1ps;
  import mhe_pkg::*;
  logic [6:0] idx;
  logic [1:0] pause;
  logic       fire;
  initial
  begin
    dma_req = '0;
    dma_start_bit = 1'b0;
    idx = 7'h00;
    pause = 2'h0;
  end
  // stops after the requested whole count
  assign fire = dma_start_bit && pause == 2'h0 && idx != len;
  // released bus toggles so stale data never looks valid
  always @(posedge clk_sys)
  begin
    dma_req.wr <= fire;
    dma_req.rd <= 1'b0;
    dma_req.addr <= fire ? `MHE_IN_LO + {10'h000, idx[5:0]} : ~dma_req.addr;
    dma_req.wdata <= fire ? msg[511 - 8 * int'(idx) -: 8] : ~dma_req.wdata;
    if (go && !dma_start_bit)
    begin
      dma_start_bit <= 1'b1;
      idx <= 7'h00;
      pause <= 2'h0;
    end
    else if (fire)
    begin
      idx <= idx + 7'h01;
      pause <= gap;
    end
    else if (pause != 2'h0)
      pause <= pause - 2'h1;
    else if (dma_start_bit)
      dma_start_bit <= 1'b0;
  end
endmodule
`default_nettype wire

// ==== mhe_engine_tb.sv ====
// self-checking testbench for the digest engine
`include "mhe_defs.svh"
`default_nettype none
module mhe_engine_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mhe_pkg::*;
  localparam logic [127:0] MD5_ABC = 128'h900150983CD24FB0D6963F7D28E17F72;
  localparam logic [159:0] SHA_ABC = 160'hA9993E364706816ABA3E25717850C26C9CD0D89D;
  localparam logic [159:0] SHA_TWO = 160'h84983E441C3BD26EBAAE4AA1F95129E5E54670F1;
  localparam logic [511:0] MSG_ABC = {24'h616263, 488'h0};
  // 56-byte tail leaves no room for the length, so a second pad block follows
  localparam logic [511:0] MSG_TWO = {128'h61626364626364656364656664656667,
    128'h65666768666768696768696A68696A6B, 128'h696A6B6C6A6B6C6D6B6C6D6E6C6D6E6F,
    64'h6D6E6F706E6F7071, 64'h0};
  localparam logic [127:0] MD5_IV  = 128'h0123456789ABCDEFFEDCBA9876543210;
  logic         clk_sys;
  logic         sys_rst;
  logic         go;
  logic [511:0] msg;
  logic [6:0]   len;
  logic [1:0]   gap;
  mhe_bus_req_s cpu_req;
  mhe_bus_req_s dma_req;
  mhe_bus_req_s bus_req;
  logic [7:0]   bus_rdata;
  logic         dma_start_bit;
  logic         block_done_flag;
  logic         hash_busy;
  int           fails;
  int           tests_run;
  // the copy engine owns the bus while it runs
  assign bus_req = dma_start_bit ? dma_req : cpu_req;
  mhe_engine dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus_req(bus_req),
    .dma_start_bit(dma_start_bit), .bus_rdata(bus_rdata),
    .block_done_flag(block_done_flag), .hash_busy(hash_busy));
  mhe_dma_model u_dma (.clk_sys(clk_sys), .go(go), .msg(msg), .len(len), .gap(gap),
    .dma_req(dma_req), .dma_start_bit(dma_start_bit));
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    cpu_req <= '{1'b1, 1'b0, a, d};
    @(posedge clk_sys);
    cpu_req <= '0;
  endtask
  task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    cpu_req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk_sys);
    cpu_req <= '0;
    #1;
    d = bus_rdata;
  endtask
  // start a copy and wait, bounded, for it to end
  task automatic dma_copy(input logic [511:0] m, input logic [6:0] n, input logic [1:0] g);
    @(posedge clk_sys);
    msg <= m;
    len <= n;
    gap <= g;
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    #1;
    for (int i = 0; i < 400 && dma_start_bit; i++)
    begin
      @(posedge clk_sys);
      #1;
    end
  endtask
  // bound in cycles is the open-loop wait software may use instead of polling
  task automatic wait_done(input int n);
    for (int i = 0; i < n && block_done_flag !== 1'b1; i++)
    begin
      @(posedge clk_sys);
      #1;
    end
    check({7'h00, block_done_flag}, 8'h01);
  endtask
  // ignored while disabled, then one block split in two copies
  task automatic t_block;
    logic [7:0] v;
    dma_copy('1, 7'd64, 2'd0);
    repeat (30) @(posedge clk_sys);
    #1;
    check({7'h00, block_done_flag}, 8'h00);
    wr_reg(`MHE_CTRL, 8'h04);
    rd_reg(`MHE_CTRL, v);
    check(v, 8'h04);
    dma_copy('1, 7'd32, 2'd0);
    dma_copy('1, 7'd32, 2'd2);
    wait_done(180);
    rd_reg(`MHE_STAT, v);
    check(v, 8'h01);
    rd_reg(`MHE_RES + 16'd26, v);
    check(v, 8'h02);
    rd_reg(`MHE_IN_LO + 16'h0010, v);
    check(v, 8'h00);
    wr_reg(`MHE_STAT, 8'h01);
    wr_reg(`MHE_CTRL, 8'h00);
  endtask
  // final message, digest and low byte of the bit length read back
  task automatic t_abc(input logic algo, input logic resume, input logic [511:0] m,
                       input logic [6:0] n, input logic [159:0] e);
    logic [7:0]   v;
    logic [7:0]   ctl;
    ctl = {6'h00, resume, algo};
    wr_reg(`MHE_CTRL, ctl);
    wr_reg(`MHE_CTRL, ctl | 8'h04);
    wr_reg(`MHE_CTRL, ctl | 8'h0C);
    dma_copy(m, n, {1'b0, algo});
    wait_done(algo ? 232 : 224);
    for (int i = 0; i < 20; i++)
    begin
      rd_reg(`MHE_RES + 16'(i), v);
      check(v, e[159 - 8 * i -: 8]);
    end
    rd_reg(`MHE_RES + 16'd27, v);
    check(v, {n[4:0], 3'b000});
    wr_reg(`MHE_STAT, 8'h01);
    #1;
    check({7'h00, block_done_flag}, 8'h00);
    wr_reg(`MHE_CTRL, 8'h00);
  endtask
  // saved start values restored instead of the built-in ones
  task automatic t_restore;
    for (int i = 0; i < 28; i++)
      wr_reg(`MHE_CTX_IN + 16'(i), i < 16 ? MD5_IV[127 - 8 * i -: 8] : 8'h00);
    t_abc(1'b0, 1'b1, MSG_ABC, 7'd3, {MD5_ABC, 32'h0});
  endtask
  task automatic give_verdict;
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // watchdog well beyond the several hundred cycles the run needs
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    give_verdict;
  end
  initial
  begin
    sys_rst = 1'b1;
    cpu_req = '0;
    go = 1'b0;
    msg = '0;
    len = 7'h00;
    gap = 2'h0;
    fails = 0;
    tests_run = 0;
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_block;
    t_abc(1'b0, 1'b0, MSG_ABC, 7'd3, {MD5_ABC, 32'h0});
    t_abc(1'b1, 1'b0, MSG_ABC, 7'd3, SHA_ABC);
    t_abc(1'b1, 1'b0, MSG_TWO, 7'd56, SHA_TWO);
    t_restore;
    give_verdict;
  end
endmodule
`default_nettype wire
